// [eol_top.v]
// eol_top.v: event and digital output conditioning with a
// classic wishbone register slave
// assumes same-clock alarm, run, set value and heater inputs;
// contact inputs arrive from pins
`timescale 1ns/1ns
`default_nettype none
`include "eol_defines.vh"
module eol_top #(
  parameter NCH     = 6,
  parameter SEC_CYC = `EOL_SEC_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // process side
  input  wire [5:0]  alarm_source,
  input  wire        scale_over,
  input  wire        run_state,
  input  wire        set_value_change,
  input  wire [7:0]  program_time_signal,
  input  wire [9:0]  external_contact_input,
  input  wire [9:0]  heater_current,
  // outputs
  output wire [2:0]  event_out,
  output wire [4:0]  digital_out,
  output reg         current_over_range
);
  // ********************
  // helpers
  // ********************
  function pick;
    input [18:0] v;
    input [4:0]  s;
    begin
      pick = (s <= `EOL_SRC_LAST) ? v[s] : 1'b0;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  sel;
    reg   [31:0] m;
    begin
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (d & m);
    end
  endfunction

  function [31:0] fixcfg;
    input [31:0] w;
    reg   [31:0] r;
    begin
      r = w;
      if (w[`EOL_F_GATA] == `EOL_G_TOG &&
          w[`EOL_F_SRCA] != `EOL_SRC_NONE &&
          w[`EOL_F_SRCA] <= `EOL_SRC_TSHI)
        r[`EOL_F_GATA] = `EOL_G_PASS;
      if (w[`EOL_F_GATB] == `EOL_G_TOG &&
          w[`EOL_F_SRCB] != `EOL_SRC_NONE &&
          w[`EOL_F_SRCB] <= `EOL_SRC_TSHI)
        r[`EOL_F_GATB] = `EOL_G_PASS;
      fixcfg = r;
    end
  endfunction

  function gate;
    input [1:0] g;
    input       x;
    input       t;
    begin
      case (g)
        `EOL_G_INV: gate = ~x;
        `EOL_G_TOG: gate = t;
        default:    gate = x;
      endcase
    end
  endfunction

  // ********************
  // second tick
  // ********************
  wire tick;
  eol_tick #(
    .SEC_CYC (SEC_CYC)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );
  localparam integer PLS_LAST_I = SEC_CYC - 1;
  localparam [27:0]  PLS_LAST   = PLS_LAST_I[27:0];

  // ********************
  // contact synchroniser
  // ********************
  reg  [9:0]  di_meta_reg;
  reg  [9:0]  di_sync_reg;
  reg         run_last_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      di_meta_reg  <= 10'h000;
      di_sync_reg  <= 10'h000;
      run_last_reg <= 1'b0;
    end else begin
      di_meta_reg  <= external_contact_input;
      di_sync_reg  <= di_meta_reg;
      run_last_reg <= run_state;
    end
  end
  wire        run_rise = run_state & ~run_last_reg;
  wire [18:0] srcvec   = {di_sync_reg, program_time_signal, 1'b0};

  // ********************
  // register file
  // ********************
  reg  [31:0] cfg_reg [0:NCH-1];
  reg  [31:0] dly_reg [0:NCH-1];
  reg  [31:0] tc_reg  [0:1];
  reg  [31:0] htr_reg;
  wire        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr_go   = wb_req & wb_we_i;
  wire        hit     = (wb_adr_i[7:6] == 2'h0);
  wire [3:0]  idx     = wb_adr_i[5:2];
  wire [2:0]  chi     = idx[3:1];
  integer     i;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < NCH; i = i + 1) begin
        cfg_reg[i] <= `EOL_RST_CFG;
        dly_reg[i] <= `EOL_RST_ZERO;
      end
      tc_reg[0] <= `EOL_RST_ZERO;
      tc_reg[1] <= `EOL_RST_ZERO;
      htr_reg   <= `EOL_RST_ZERO;
    end else if (wr_go && hit) begin
      if (idx < 4'hC && chi < NCH) begin
        if (idx[0])
          dly_reg[chi] <= merge(dly_reg[chi], wb_dat_i, wb_sel_i);
        else
          cfg_reg[chi] <= fixcfg(merge(cfg_reg[chi], wb_dat_i,
                                       wb_sel_i));
      end else if ({wb_adr_i[7:2], 2'h0} == `EOL_OFS_TC0) begin
        tc_reg[0] <= merge(tc_reg[0], wb_dat_i, wb_sel_i);
      end else if ({wb_adr_i[7:2], 2'h0} == `EOL_OFS_TC1) begin
        tc_reg[1] <= merge(tc_reg[1], wb_dat_i, wb_sel_i);
      end else if ({wb_adr_i[7:2], 2'h0} == `EOL_OFS_HTR) begin
        htr_reg <= merge(htr_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ********************
  // heater alarms
  // ********************
  reg         hb_reg;
  reg         hl_reg;
  wire [9:0]  hb_sp = {1'b0, htr_reg[`EOL_F_HBSP]};
  wire [9:0]  hl_sp = {1'b0, htr_reg[`EOL_F_HLSP]};
  wire        latch = htr_reg[`EOL_F_HLAT];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hb_reg             <= 1'b0;
      hl_reg             <= 1'b0;
      current_over_range <= 1'b0;
    end else begin
      current_over_range <= (heater_current > `EOL_OVR);
      if (hb_sp == 10'h000)
        hb_reg <= 1'b0;
      else if (heater_current < hb_sp)
        hb_reg <= 1'b1;
      else if (!latch && heater_current >= hb_sp + `EOL_HYST)
        hb_reg <= 1'b0;
      if (hl_sp == 10'h000)
        hl_reg <= 1'b0;
      else if (heater_current > hl_sp)
        hl_reg <= 1'b1;
      else if (!latch && {1'b0, heater_current} + {1'b0, `EOL_HYST} <=
               {1'b0, hl_sp})
        hl_reg <= 1'b0;
    end
  end

  // ********************
  // conditioned channels
  // ********************
  wire [NCH-1:0] act_w;
  wire [NCH-1:0] nc_w;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      wire [31:0] c    = cfg_reg[g];
      wire [4:0]  md   = c[`EOL_F_MODE];
      wire [1:0]  ih   = c[`EOL_F_INH];
      wire        ina  = pick(srcvec, c[`EOL_F_SRCA]);
      wire        inb  = pick(srcvec, c[`EOL_F_SRCB]);
      wire        cond = alarm_source[g];
      wire        ih12 = (ih == `EOL_IH_ONE) || (ih == `EOL_IH_TWO);
      reg         inh_reg;
      reg  [13:0] dcnt_reg;
      reg         ina_last_reg;
      reg         inb_last_reg;
      reg         tga_reg;
      reg         tgb_reg;
      wire        qual;
      wire        dly_ok;
      wire        ga;
      wire        gb;
      reg         lg;
      reg         act;
      // inhibit holds until leave and re-entry
      assign qual = cond & ~(inh_reg & ih12);
      assign dly_ok = (dcnt_reg >= dly_reg[g][`EOL_F_DLY]);
      assign ga = gate(c[`EOL_F_GATA], ina, tga_reg);
      assign gb = gate(c[`EOL_F_GATB], inb, tgb_reg);
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          inh_reg      <= 1'b1;
          dcnt_reg     <= 14'h0000;
          ina_last_reg <= 1'b0;
          inb_last_reg <= 1'b0;
          tga_reg      <= 1'b0;
          tgb_reg      <= 1'b0;
        end else begin
          // arm on run start, and on set value change for EOL_IH_TWO only
          if ((ih12 && run_rise) ||
              (ih == `EOL_IH_TWO && set_value_change))
            inh_reg <= 1'b1;
          else if (!cond)
            inh_reg <= 1'b0;
          if (!qual)
            dcnt_reg <= 14'h0000;
          else if (tick && dcnt_reg != 14'h3FFF)
            dcnt_reg <= dcnt_reg + 14'h0001;
          ina_last_reg <= ina;
          inb_last_reg <= inb;
          if (ina && !ina_last_reg)
            tga_reg <= ~tga_reg;
          if (inb && !inb_last_reg)
            tgb_reg <= ~tgb_reg;
        end
      end
      always @* begin
        case (c[`EOL_F_LFN])
          `EOL_LF_OR:  lg = ga | gb;
          `EOL_LF_XOR: lg = ga ^ gb;
          default:     lg = ga & gb;
        endcase
        if (c[`EOL_F_SRCA] == `EOL_SRC_NONE ||
            c[`EOL_F_SRCB] == `EOL_SRC_NONE)
          lg = 1'b0;
        act = 1'b0;
        // delay and inhibit only for alarm modes
        if (md >= `EOL_MD_ALO && md <= `EOL_MD_AHI) begin
          if (scale_over)
            act = (ih != `EOL_IH_SOOFF);
          else
            act = qual & dly_ok;
        // logic on the six conditioned outputs
        end else if (md == `EOL_MD_LOGIC) begin
          act = lg;
        end else if (md == `EOL_MD_HBA) begin
          act = hb_reg;
        end else if (md == `EOL_MD_HLA) begin
          act = hl_reg;
        end
      end
      assign act_w[g] = act;
      assign nc_w[g]  = c[`EOL_F_NC];
    end
  endgenerate

  // ********************
  // timers and counters
  // ********************
  wire [1:0] pls_w;
  wire [1:0] tnc_w;
  generate
    for (g = 0; g < 2; g = g + 1) begin : tc
      wire [31:0] t    = tc_reg[g];
      wire [12:0] pre  = t[`EOL_F_PRE];
      wire        tin  = pick(srcvec, t[`EOL_F_TSRC]);
      reg         tin_last_reg;
      reg         run_reg;
      reg  [12:0] cnt_reg;
      reg  [27:0] pls_reg;
      wire        rise = tin & ~tin_last_reg;
      wire        fire_t;
      wire        fire_c;
      assign fire_t = ~t[`EOL_F_CNTM] & run_reg & tick &
                      (cnt_reg + 13'h0001 == pre);
      // relies on 100 ms contact pulses
      assign fire_c = t[`EOL_F_CNTM] & rise &
                      (cnt_reg + 13'h0001 == pre);
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          tin_last_reg <= 1'b0;
          run_reg      <= 1'b0;
          cnt_reg      <= 13'h0000;
          pls_reg      <= 28'h0000000;
        end else begin
          tin_last_reg <= tin;
          if (pre == 13'h0000) begin
            run_reg <= 1'b0;
            cnt_reg <= 13'h0000;
          end else if (t[`EOL_F_CNTM]) begin
            run_reg <= 1'b0;
            if (fire_c)
              cnt_reg <= 13'h0000;
            else if (rise)
              cnt_reg <= cnt_reg + 13'h0001;
          end else if (rise) begin
            run_reg <= 1'b1;
            cnt_reg <= 13'h0000;
          end else if (fire_t) begin
            run_reg <= 1'b0;
          end else if (run_reg && tick) begin
            cnt_reg <= cnt_reg + 13'h0001;
          end
          if (fire_t || fire_c)
            pls_reg <= PLS_LAST;
          else if (pls_reg != 28'h0000000)
            pls_reg <= pls_reg - 28'h0000001;
        end
      end
      assign pls_w[g] = fire_t | fire_c | (pls_reg != 28'h0000000);
      assign tnc_w[g] = t[`EOL_F_TNC];
    end
  endgenerate

  // ********************
  // output drive
  // ********************
  reg [7:0] out_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      out_reg <= 8'h00;
    end else begin
      out_reg <= {pls_w ^ tnc_w, act_w ^ nc_w};
    end
  end
  assign event_out   = out_reg[2:0];
  assign digital_out = out_reg[7:3];

  // ********************
  // bus answer
  // ********************
  reg [31:0] rd_w;
  always @* begin
    rd_w = 32'h0000_0000;
    if (hit) begin
      if (idx < 4'hC && chi < NCH)
        rd_w = idx[0] ? dly_reg[chi] : cfg_reg[chi];
      else if ({wb_adr_i[7:2], 2'h0} == `EOL_OFS_TC0)
        rd_w = tc_reg[0];
      else if ({wb_adr_i[7:2], 2'h0} == `EOL_OFS_TC1)
        rd_w = tc_reg[1];
      else if ({wb_adr_i[7:2], 2'h0} == `EOL_OFS_HTR)
        rd_w = htr_reg;
      else if ({wb_adr_i[7:2], 2'h0} == `EOL_OFS_STAT)
        rd_w = {21'h000000, current_over_range, hl_reg, hb_reg,
                out_reg};
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_w : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [eol_defines.vh]
// eol_defines.vh: constants of the event output block
// assumes inclusion by bare name from the eol_top module only
`ifndef EOL_DEFINES_VH
`define EOL_DEFINES_VH
// ********************
// register offsets
// ********************
`define EOL_OFS_CFG0  8'h00
`define EOL_OFS_DLY0  8'h04
`define EOL_OFS_TC0   8'h30
`define EOL_OFS_TC1   8'h34
`define EOL_OFS_HTR   8'h38
`define EOL_OFS_STAT  8'h3C
// ********************
// channel fields
// ********************
`define EOL_F_MODE    4:0
`define EOL_F_NC      5
`define EOL_F_INH     7:6
`define EOL_F_LFN     9:8
`define EOL_F_SRCA    14:10
`define EOL_F_SRCB    19:15
`define EOL_F_GATA    21:20
`define EOL_F_GATB    23:22
`define EOL_F_DLY     13:0
// ********************
// timer/counter fields
// ********************
`define EOL_F_PRE     12:0
`define EOL_F_CNTM    13
`define EOL_F_TSRC    18:14
`define EOL_F_TNC     19
// ********************
// heater fields
// ********************
`define EOL_F_HBSP    8:0
`define EOL_F_HLSP    17:9
`define EOL_F_HLAT    18
// ********************
// reset values
// ********************
`define EOL_RST_CFG   32'h0000_0001
`define EOL_RST_ZERO  32'h0000_0000
// ********************
// encodings
// ********************
`define EOL_MD_ALO    5'h02
`define EOL_MD_AHI    5'h07
`define EOL_MD_LOGIC  5'h0C
`define EOL_MD_HBA    5'h1A
`define EOL_MD_HLA    5'h1B
`define EOL_LF_AND    2'h0
`define EOL_LF_OR     2'h1
`define EOL_LF_XOR    2'h2
`define EOL_G_INV     2'h1
`define EOL_G_TOG     2'h2
`define EOL_G_PASS    2'h0
`define EOL_IH_ONE    2'h1
`define EOL_IH_TWO    2'h2
`define EOL_IH_SOOFF  2'h3
`define EOL_SRC_NONE  5'h00
`define EOL_SRC_TSHI  5'h08
`define EOL_SRC_LAST  5'h12
// ********************
// timing and current
// ********************
`define EOL_CLK_NS    4
`define EOL_SEC_NS    1000000000
`define EOL_SEC_CYC   (`EOL_SEC_NS / `EOL_CLK_NS)
`define EOL_HYST      10'h002
`define EOL_OVR       10'h226
`endif

// [eol_tick.v]
// eol_tick.v: one-second tick from the system clock
// assumes clk and async active-high rst
`timescale 1ns/1ns
`default_nettype none
module eol_tick #(
  parameter SEC_CYC = 250000000
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // one-cycle pulse each second
  output reg  tick
);
  localparam integer LAST_I = SEC_CYC - 1;
  localparam [27:0]  LAST   = LAST_I[27:0];
  reg [27:0] cnt_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 28'h0000000;
      tick    <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= 28'h0000000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 28'h0000001;
      tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [eol_top_monitor.sv]
// eol_top_monitor.sv: port assertions for the event output block
// assumes bind to eol_top, one clock, async active-high reset
`timescale 1ns/1ns
`default_nettype none
module eol_top_monitor #(
  parameter SEC_CYC = 20
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // process side
  input wire logic [9:0]  heater_current,
  input wire logic [4:0]  digital_out,
  input wire logic        current_over_range
);
  // ****************
  // pulse length
  // ****************
  logic [31:0] run_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      run_cnt <= 32'h0;
    else if (digital_out[3])
      run_cnt <= run_cnt + 32'h1;
    else
      run_cnt <= 32'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // assertions
  // ****************
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_cause: assert property
    ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i
    && !wb_ack_o && wb_adr_i >= 8'h40 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_over_set: assert property
    (heater_current > 10'h226 |=> current_over_range)
    else $error("over-range flag missing");
  chk_over_clear: assert property
    (heater_current <= 10'h226 |=> !current_over_range)
    else $error("over-range flag false");
  chk_pulse_len: assert property ($fell(digital_out[3]) |->
    run_cnt >= SEC_CYC && run_cnt <= SEC_CYC + 1)
    else $error("timer pulse length wrong");
  chk_pulse_min: assert property
    ($rose(digital_out[4]) |-> digital_out[4] [*8])
    else $error("counter pulse too short");
endmodule
bind eol_top eol_top_monitor #(.SEC_CYC(SEC_CYC)) i_mon (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .heater_current(heater_current),
  .digital_out(digital_out), .current_over_range(current_over_range));
`default_nettype wire

// [eol_far_side.sv]
// eol_far_side.sv: contact inputs and heater current sensor model
// assumes bench requests levels; each contact level is held at least HOLD_CYC cycles, heater current follows next cycle
`timescale 1ns/1ns
`default_nettype none
module eol_far_side #(
  parameter HOLD_CYC = 2
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // requests from bench
  input  wire logic [9:0] contact_want,
  input  wire logic [9:0] amps_want,
  // pins toward block
  output var  logic [9:0] external_contact_input,
  output var  logic [9:0] heater_current
);
  int hold;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      external_contact_input <= 10'h000;
      heater_current <= 10'h000;
      hold <= 0;
    end else begin
      heater_current <= amps_want;
      if (contact_want != external_contact_input && hold >= HOLD_CYC) begin
        external_contact_input <= contact_want;
        hold <= 0;
      end else if (hold < HOLD_CYC)
        hold <= hold + 1;
    end
  end
endmodule
`default_nettype wire

// [eol_top_tb.sv]
// eol_top_tb.sv: self-checking bench for the event output block
// assumes eol_top, its monitor and eol_far_side are compiled
`timescale 1ns/1ns
`default_nettype none
module eol_top_tb;
  localparam int SEC = 20;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [5:0]  src;
  logic        so;
  logic        run;
  logic        svc;
  logic [7:0]  ts;
  logic [9:0]  cwant;
  logic [9:0]  awant;
  logic [9:0]  ci;
  logic [9:0]  amps;
  logic [2:0]  ev;
  logic [4:0]  dout;
  logic        ovr;
  int          n_errors;
  int          check_count;
  wire  [7:0]  outs = {dout, ev};
  eol_top #(.SEC_CYC(SEC)) i_dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat),
    .wb_ack_o(ack), .alarm_source(src), .scale_over(so),
    .run_state(run), .set_value_change(svc), .program_time_signal(ts),
    .external_contact_input(ci), .heater_current(amps),
    .event_out(ev), .digital_out(dout), .current_over_range(ovr));
  eol_far_side #(.HOLD_CYC(SEC / 10)) i_far (
    .clk(clk), .rst(rst), .contact_want(cwant), .amps_want(awant),
    .external_contact_input(ci), .heater_current(amps));
  // ****************
  // helpers
  // ****************
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  function automatic logic [31:0] cfg(input logic [4:0] md,
    input logic [1:0] ih, input logic [1:0] fn, input logic [4:0] sa,
    input logic [4:0] sb, input logic [1:0] ga);
    return {10'h000, ga, sb, sa, fn, ih, 1'b0, md};
  endfunction
  task automatic wait_hi(input int b, input int lim, output int n);
    n = 0;
    while (outs[b] !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic pulse(input int b);
    cwant[b] <= 1'b1;
    cy(6);
    cwant[b] <= 1'b0;
    cy(8);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    rchk(8'h00, 32'h0000_0001);
    rchk(8'h04, 32'h0000_0000);
    rchk(8'h30, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0000_0000);
    wr(8'h3C, 32'hFFFF_FFFF);
    rchk(8'h3C, 32'h0000_0000);
  endtask
  task automatic t_delay();
    int n;
    wr(8'h00, cfg(5'h02, 2'h0, 2'h0, 5'h00, 5'h00, 2'h0));
    src[0] <= 1'b1;
    cy(2);
    chk(outs[0], 1'b1);
    wr(8'h00, cfg(5'h02, 2'h0, 2'h0, 5'h00, 5'h00, 2'h0) | 32'h20);
    cy(2);
    chk(outs[0], 1'b0);
    src[0] <= 1'b0;
    wr(8'h00, cfg(5'h02, 2'h0, 2'h0, 5'h00, 5'h00, 2'h0));
    wr(8'h04, 32'h0000_0003);
    src[0] <= 1'b1;
    cy(SEC + SEC / 2);
    chk(outs[0], 1'b0);
    src[0] <= 1'b0;
    cy(2);
    src[0] <= 1'b1;
    wait_hi(0, 4 * SEC, n);
    chk(n >= 2 * SEC && n <= 3 * SEC + 4, 1'b1);
    src[0] <= 1'b0;
    cy(2);
    src[0] <= 1'b1;
    cy(SEC + 2);
    wr(8'h04, 32'h0000_0001);
    cy(2);
    chk(outs[0], 1'b1);
    src[0] <= 1'b0;
  endtask
  task automatic t_inhibit();
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, cfg(5'h02, 2'h1, 2'h0, 5'h00, 5'h00, 2'h0));
    src[0] <= 1'b1;
    cy(3);
    chk(outs[0], 1'b1);
    run <= 1'b1;
    cy(3);
    chk(outs[0], 1'b0);
    src[0] <= 1'b0;
    cy(3);
    src[0] <= 1'b1;
    cy(3);
    chk(outs[0], 1'b1);
    svc <= 1'b1;
    cy(1);
    svc <= 1'b0;
    cy(3);
    chk(outs[0], 1'b1);
    wr(8'h00, cfg(5'h02, 2'h2, 2'h0, 5'h00, 5'h00, 2'h0));
    svc <= 1'b1;
    cy(1);
    svc <= 1'b0;
    cy(3);
    chk(outs[0], 1'b0);
    wr(8'h00, cfg(5'h02, 2'h0, 2'h0, 5'h00, 5'h00, 2'h0));
    cy(3);
    chk(outs[0], 1'b1);
    src[0] <= 1'b0;
    so <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, cfg(5'h02, i[1:0], 2'h0, 5'h00, 5'h00, 2'h0));
      cy(2);
      chk(outs[0], i != 3);
    end
    so <= 1'b0;
  endtask
  task automatic t_logic();
    logic [31:0] q;
    logic        a;
    logic        e;
    wr(8'h04, 32'h0000_0005);
    for (int c = 0; c < 6; c += 3)
      for (int f = 0; f < 3; f++)
        for (int g = 0; g < 2; g++) begin
          wr(8'(c * 8), cfg(5'h0C, 2'h0, f[1:0], 5'h01, 5'h02, g[1:0]));
          for (int v = 0; v < 4; v++) begin
            ts <= v[7:0];
            cy(3);
            a = v[0] ^ g[0];
            e = (f == 0) ? (a & v[1]) : (f == 1) ? (a | v[1]) : (a ^ v[1]);
            chk(outs[c], e);
          end
        end
    wr(8'h00, cfg(5'h0C, 2'h0, 2'h1, 5'h00, 5'h02, 2'h0));
    ts <= 8'h03;
    cy(3);
    chk(outs[0], 1'b0);
    ts <= 8'h02;
    wr(8'h00, cfg(5'h0C, 2'h0, 2'h0, 5'h01, 5'h02, 2'h2));
    bus(1'b0, 8'h00, 32'h0, q);
    chk(q[21:20], 2'h0);
    wr(8'h00, cfg(5'h0C, 2'h0, 2'h0, 5'h09, 5'h02, 2'h2));
    ts <= 8'h02;
    pulse(0);
    chk(outs[0], 1'b1);
    pulse(0);
    chk(outs[0], 1'b0);
  endtask
  task automatic t_tc();
    int n;
    ts <= 8'h00;
    wr(8'h30, 32'h0000_C002);
    ts <= 8'h04;
    wait_hi(6, 4 * SEC, n);
    chk(n >= SEC && n <= 2 * SEC + 4, 1'b1);
    cy(SEC - 2);
    chk(outs[6], 1'b1);
    cy(4);
    chk(outs[6], 1'b0);
    wr(8'h34, 32'h0002_A003);
    pulse(1);
    pulse(1);
    chk(outs[7], 1'b0);
    cwant[1] <= 1'b1;
    wait_hi(7, 20, n);
    chk(n < 20, 1'b1);
    cwant[1] <= 1'b0;
    wr(8'h34, 32'h0008_0000);
    cy(SEC + 2);
    chk(outs[7], 1'b1);
  endtask
  task automatic t_heater();
    logic [9:0] cur [6] = '{10'h032, 10'h065, 10'h066, 10'h136, 10'h12B,
                            10'h12A};
    logic [1:0] hx [6] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0};
    wr(8'h08, cfg(5'h1A, 2'h0, 2'h0, 5'h00, 5'h00, 2'h0));
    wr(8'h10, cfg(5'h1B, 2'h0, 2'h0, 5'h00, 5'h00, 2'h0));
    wr(8'h38, 32'h0002_5864);
    for (int i = 0; i < 6; i++) begin
      awant <= cur[i];
      cy(4);
      chk(outs[2:1], hx[i]);
      chk(outs[4], 1'b0);
    end
    wr(8'h38, 32'h0006_5864);
    awant <= 10'h032;
    cy(4);
    awant <= 10'h0C8;
    cy(4);
    chk(outs[1], 1'b1);
    wr(8'h38, 32'h0006_5800);
    cy(2);
    chk(outs[1], 1'b0);
    awant <= 10'h226;
    cy(4);
    chk(ovr, 1'b0);
    awant <= 10'h227;
    cy(4);
    chk(ovr, 1'b1);
    rst <= 1'b1;
    cy(2);
    chk(outs, 8'h00);
    rst <= 1'b0;
    cy(1);
    rchk(8'h08, 32'h0000_0001);
  endtask
  // ****************
  // run control
  // ****************
  task automatic results();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, cyc, stb, we, so, run, svc} = 7'h40;
    {adr, wdat, src, ts, cwant, awant} = 74'h0;
    n_errors = 0;
    check_count = 0;
    cy(5);
    rst <= 1'b0;
    cy(1);
    t_regs();
    t_delay();
    t_inhibit();
    t_logic();
    t_tc();
    t_heater();
    results();
  end
  initial begin
    cy(20000);
    n_errors++;
    $display("watchdog expired");
    results();
  end
endmodule
`default_nettype wire
